// ===== hdl/rales_top.sv
// alarm, indicator and control pin encoder with axi4-lite registers
//
// Our own choices: the AXI4-Lite interface to the registers and the register addresses.
`default_nettype none
// Operation
// - thermal alarm: service lit, over-temperature low, others as normal
// - fan, fuse, boost or overvoltage latch: output-good off, fault lit, low
// - input out of limits: input-good blinks, other indicators dark
// - no input power: indicators off, power-fail low, fault and otw high
// - non-shutdown internal failure: fault lit and fault output low
// - power-fail warning goes low a lead time before output falls while input is present; input loss drops output at once
// - power-fail follows boost decay, not input regulation
// - over-temperature high normally, low at the thermal margin
// - fault output high normally, low on fault
// - capacity high at full rating, low at reduced rating
// - output-enable tied low turns output on in analog and bus modes
// - protocol strap picks bus-managed or serial mode
// - hot-plug on/off pin gates the main output
// - mux reset input resets the internal bus multiplexer
module rales_top #(
  parameter int PFW_LEAD_CYC   = rales_pkg::PFW_LEAD_CYC,
  parameter int BLINK_HALF_CYC = rales_pkg::BLINK_HALF_CYC
) (
  // clock and reset
  input  wire logic                        aclk,
  input  wire logic                        aresetn,
  // axi4-lite write
  input  wire logic [rales_pkg::ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                        s_axi_awvalid,
  output var  logic                        s_axi_awready,
  input  wire logic [31:0]                 s_axi_wdata,
  input  wire logic [3:0]                  s_axi_wstrb,
  input  wire logic                        s_axi_wvalid,
  output var  logic                        s_axi_wready,
  output var  logic [1:0]                  s_axi_bresp,
  output var  logic                        s_axi_bvalid,
  input  wire logic                        s_axi_bready,
  // axi4-lite read
  input  wire logic [rales_pkg::ADDR_W-1:0] s_axi_araddr,
  input  wire logic                        s_axi_arvalid,
  output var  logic                        s_axi_arready,
  output var  logic [31:0]                 s_axi_rdata,
  output var  logic [1:0]                  s_axi_rresp,
  output var  logic                        s_axi_rvalid,
  input  wire logic                        s_axi_rready,
  // rectifier condition inputs (asynchronous)
  input  wire logic                        thermal_alarm,
  input  wire logic                        thermal_shutdown,
  input  wire logic                        fan_fail,
  input  wire logic                        fuse_blown,
  input  wire logic                        boost_fail,
  input  wire logic                        ov_latched,
  input  wire logic                        input_present,
  input  wire logic                        input_in_limits,
  input  wire logic                        over_current,
  input  wire logic                        internal_fail,
  input  wire logic                        boost_decayed,
  input  wire logic                        full_rating,
  // control pins (asynchronous)
  input  wire logic                        output_enable_n,
  input  wire logic                        onoff_n,
  input  wire logic                        protocol_strap,
  input  wire logic                        mux_reset_req_n,
  // front panel indicators
  output var  logic                        led_input_good,
  output var  logic                        led_output_good,
  output var  logic                        led_service,
  output var  logic                        led_fault,
  // open-drain alarm pins, enable pulls low
  output var  logic                        fault_o,
  output var  logic                        fault_oe,
  output var  logic                        power_fail_warning_o,
  output var  logic                        power_fail_warning_oe,
  output var  logic                        otw_o,
  output var  logic                        otw_oe,
  output var  logic                        capacity_level_o,
  output var  logic                        capacity_level_oe,
  output var  logic                        module_present_flag_o,
  output var  logic                        module_present_flag_oe,
  // power train and multiplexer control
  output var  logic                        main_output_on,
  output var  logic                        mux_reset,
  // interrupt
  output var  logic                        irq
);
  import rales_pkg::*;

  // ************************************************************
  // pin synchronisers
  // ************************************************************
  localparam int NPIN = 16;
  logic [NPIN-1:0] pin_raw;
  logic [NPIN-1:0] s1_r;
  logic [NPIN-1:0] s2_r;

  assign pin_raw = {thermal_alarm, thermal_shutdown, fan_fail, fuse_blown,
                    boost_fail, ov_latched, input_present, input_in_limits,
                    over_current, internal_fail, boost_decayed, full_rating,
                    output_enable_n, onoff_n, protocol_strap,
                    mux_reset_req_n};

  // two flops per pin; only the second stage feeds logic
  genvar gi;
  generate
    for (gi = 0; gi < NPIN; gi++) begin : g_sync
      // no reset, so the strap level is already settled at release
      always_ff @(posedge aclk) begin
        s1_r[gi] <= pin_raw[gi];
        s2_r[gi] <= s1_r[gi];
      end
    end
  endgenerate

  logic t_alarm, t_shut, fan_f, fuse_f, boost_f, ovl, in_pres, in_lim;
  logic ocur, int_f, b_decay, full_r, en_n, onoff_sn, strap, muxr_n;
  assign {t_alarm, t_shut, fan_f, fuse_f, boost_f, ovl, in_pres, in_lim,
          ocur, int_f, b_decay, full_r, en_n, onoff_sn, strap,
          muxr_n} = s2_r;

  // ************************************************************
  // blink source
  // ************************************************************
  logic blink;
  rales_blink #(
    .HALF_CYC (BLINK_HALF_CYC)
  ) u_blink (
    .aclk    (aclk),
    .aresetn (aresetn),
    .blink   (blink)
  );

  // ************************************************************
  // mode and output gating
  // ************************************************************
  logic [CTRL_W-1:0] ctrl_r;
  logic              strap_done_r;
  logic              strap_done_nxt;
  logic              serial_r;
  logic              serial_nxt;
  rales_mode_e       mode;
  logic              fatal;
  logic              out_req;
  logic [31:0]       lead_r;
  logic [31:0]       lead_nxt;
  logic              on_r;
  logic              on_nxt;
  logic              pfw_low;

  // strap caught once after reset release, then held
  always_comb begin
    strap_done_nxt = 1'b1;
    serial_nxt     = strap_done_r ? serial_r : strap;
  end

  always_comb begin
    if (serial_r) mode = MODE_SERIAL;
    else if (ctrl_r[CTRL_ANALOG]) mode = MODE_ANALOG;
    else mode = MODE_BUS;
  end

  assign fatal   = fan_f | fuse_f | boost_f | ovl;
  // enable pin only counts outside serial mode; hot-plug pin always gates
  assign out_req = in_pres && !t_shut && !fatal && !onoff_sn &&
                   ((mode == MODE_SERIAL) ? ctrl_r[CTRL_OUT_ON]
                                          : !en_n);

  // output held on for the lead time after the warning goes low while input is
  // present, so the shelf sees the warning first; input loss drops it at once
  always_comb begin
    lead_nxt = 32'h0;
    on_nxt   = on_r;
    if (out_req) begin
      on_nxt = 1'b1;
    end else if (!in_pres) begin
      on_nxt = 1'b0;                    // nothing left to hold up
    end else if (on_r) begin
      lead_nxt = lead_r + 32'h1;
      if (lead_r >= 32'(PFW_LEAD_CYC - 1)) begin
        on_nxt   = 1'b0;
        lead_nxt = 32'h0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      strap_done_r <= 1'b0;
      serial_r     <= 1'b0;
      lead_r       <= 32'h0;
      on_r         <= 1'b0;
    end else begin
      strap_done_r <= strap_done_nxt;
      serial_r     <= serial_nxt;
      lead_r       <= lead_nxt;
      on_r         <= on_nxt;
    end
  end

  // ************************************************************
  // condition encoder
  // ************************************************************
  logic ig, og, svc, flt, fault_low, otw_low;

  // highest priority condition first
  always_comb begin
    ig = 1'b1; og = 1'b1; svc = 1'b0; flt = 1'b0;
    fault_low = 1'b0; otw_low = 1'b0; pfw_low = 1'b0;
    if (!in_pres) begin
      ig = 1'b0; og = 1'b0;
      pfw_low = 1'b1;
    end else if (t_shut) begin
      og = 1'b0; svc = 1'b1; flt = 1'b1;
      fault_low = 1'b1; otw_low = 1'b1; pfw_low = 1'b1;
    end else if (fatal) begin
      og = 1'b0; flt = 1'b1;
      fault_low = 1'b1; pfw_low = 1'b1;
    end else if (!in_lim) begin
      ig = blink; og = 1'b0;
      pfw_low = b_decay;
    end else if (ocur) begin
      og = blink; pfw_low = 1'b1;
    end else if (!out_req) begin
      og = 1'b0; pfw_low = 1'b1;                       // standby
    end else begin
      if (int_f) begin
        flt = 1'b1; fault_low = 1'b1;
      end
      if (t_alarm) begin
        svc = 1'b1; otw_low = 1'b1;
      end else if (ctrl_r[CTRL_SVC_REQ] && mode == MODE_BUS) begin
        svc = blink;
      end
      if (ctrl_r[CTRL_COMM] && mode == MODE_SERIAL && !int_f) begin
        flt = blink;
      end
    end
    if (in_pres && b_decay) pfw_low = 1'b1;
  end

  // ************************************************************
  // registered pin outputs
  // ************************************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      led_input_good         <= 1'b0;
      led_output_good        <= 1'b0;
      led_service            <= 1'b0;
      led_fault              <= 1'b0;
      fault_oe               <= 1'b0;
      otw_oe                 <= 1'b0;
      power_fail_warning_oe  <= 1'b1;
      capacity_level_oe      <= 1'b1;
      module_present_flag_oe <= 1'b1;
      main_output_on         <= 1'b0;
      mux_reset              <= 1'b1;
    end else begin
      led_input_good         <= ig;
      led_output_good        <= og && on_r;
      led_service            <= svc;
      led_fault              <= flt;
      fault_oe               <= fault_low;
      otw_oe                 <= otw_low;
      power_fail_warning_oe  <= pfw_low;
      capacity_level_oe      <= !full_r;
      module_present_flag_oe <= 1'b1;
      main_output_on         <= on_r;
      mux_reset              <= !muxr_n;
    end
  end

  // open-drain pins only ever pull low
  always_ff @(posedge aclk) begin
    fault_o               <= 1'b0;
    otw_o                 <= 1'b0;
    power_fail_warning_o  <= 1'b0;
    capacity_level_o      <= 1'b0;
    module_present_flag_o <= 1'b0;
  end

  // ************************************************************
  // interrupt status
  // ************************************************************
  logic [EV_W-1:0] lvl;
  logic [EV_W-1:0] lvl_r;
  logic [EV_W-1:0] istat_r;
  logic [EV_W-1:0] istat_nxt;
  logic [EV_W-1:0] imask_r;
  logic [EV_W-1:0] imask_nxt;
  logic [CTRL_W-1:0] ctrl_nxt;
  logic [EV_W-1:0] w1c;
  logic            wr_fire;
  logic [ADDR_W-1:0] wa_r;
  logic [31:0]     wd_r;
  logic [3:0]      ws_r;

  assign lvl = {!full_r, pfw_low, otw_low, fault_low};

  // set on each alarm assertion; set beats a same-cycle clear
  always_comb begin
    ctrl_nxt  = ctrl_r;
    imask_nxt = imask_r;
    w1c       = '0;
    if (wr_fire && ws_r[0]) begin
      unique case (wa_r)
        CTRL_OFS:  ctrl_nxt  = wd_r[CTRL_W-1:0];
        IMASK_OFS: imask_nxt = wd_r[EV_W-1:0];
        ISTAT_OFS: w1c       = wd_r[EV_W-1:0];
        default:   ctrl_nxt  = ctrl_r;
      endcase
    end
    istat_nxt = (istat_r & ~w1c) | (lvl & ~lvl_r);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_r  <= CTRL_RST;
      imask_r <= IMASK_RST;
      istat_r <= '0;
      lvl_r   <= '0;
      irq     <= 1'b0;
    end else begin
      ctrl_r  <= ctrl_nxt;
      imask_r <= imask_nxt;
      istat_r <= istat_nxt;
      lvl_r   <= lvl;
      irq     <= |(istat_nxt & imask_nxt);
    end
  end

  // ************************************************************
  // axi4-lite slave
  // ************************************************************
  logic aw_got_r, w_got_r, aw_got_nxt, w_got_nxt, bvalid_nxt;
  logic [1:0] bresp_nxt;
  logic [ADDR_W-1:0] wa_nxt;
  logic [31:0] wd_nxt;
  logic [3:0]  ws_nxt;
  logic        rvalid_nxt;
  logic [31:0] rdata_nxt;
  logic [1:0]  rresp_nxt;
  logic [31:0] state_word;

  assign state_word = {20'h0, 2'(mode), on_r, serial_r,
                       led_input_good, led_output_good, led_service,
                       led_fault, fault_low, otw_low, pfw_low, full_r};
  assign wr_fire = aw_got_r && w_got_r && !s_axi_bvalid;

  // address and data taken in either order, one write at a time
  always_comb begin
    aw_got_nxt = aw_got_r;
    w_got_nxt  = w_got_r;
    wa_nxt = wa_r; wd_nxt = wd_r; ws_nxt = ws_r;
    bvalid_nxt = s_axi_bvalid;
    bresp_nxt  = s_axi_bresp;
    if (s_axi_awvalid && s_axi_awready) begin
      aw_got_nxt = 1'b1; wa_nxt = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      w_got_nxt = 1'b1; wd_nxt = s_axi_wdata; ws_nxt = s_axi_wstrb;
    end
    if (wr_fire) begin
      aw_got_nxt = 1'b0; w_got_nxt = 1'b0; bvalid_nxt = 1'b1;
      bresp_nxt = (wa_r == CTRL_OFS || wa_r == IMASK_OFS ||
                   wa_r == ISTAT_OFS) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bvalid && s_axi_bready) begin
      bvalid_nxt = 1'b0;
    end
  end

  // read answers one cycle after the address is taken
  always_comb begin
    rvalid_nxt = s_axi_rvalid;
    rdata_nxt  = s_axi_rdata;
    rresp_nxt  = s_axi_rresp;
    if (s_axi_arvalid && s_axi_arready) begin
      rvalid_nxt = 1'b1;
      rresp_nxt  = RESP_OKAY;
      unique case (s_axi_araddr)
        CTRL_OFS:  rdata_nxt = {28'h0, ctrl_r};
        STATE_OFS: rdata_nxt = state_word;
        ISTAT_OFS: rdata_nxt = {28'h0, istat_r};
        IMASK_OFS: rdata_nxt = {28'h0, imask_r};
        default: begin
          rdata_nxt = 32'h0;
          rresp_nxt = RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      rvalid_nxt = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_r <= 1'b0; w_got_r <= 1'b0;
      wa_r <= '0; wd_r <= 32'h0; ws_r <= 4'h0;
      s_axi_awready <= 1'b0; s_axi_wready <= 1'b0;
      s_axi_bvalid  <= 1'b0; s_axi_bresp  <= RESP_OKAY;
      s_axi_arready <= 1'b0; s_axi_rvalid <= 1'b0;
      s_axi_rdata   <= 32'h0; s_axi_rresp <= RESP_OKAY;
    end else begin
      aw_got_r <= aw_got_nxt; w_got_r <= w_got_nxt;
      wa_r <= wa_nxt; wd_r <= wd_nxt; ws_r <= ws_nxt;
      s_axi_awready <= !aw_got_nxt && !bvalid_nxt;
      s_axi_wready  <= !w_got_nxt && !bvalid_nxt;
      s_axi_bvalid  <= bvalid_nxt; s_axi_bresp <= bresp_nxt;
      s_axi_arready <= !rvalid_nxt;
      s_axi_rvalid  <= rvalid_nxt;
      s_axi_rdata   <= rdata_nxt; s_axi_rresp <= rresp_nxt;
    end
  end
endmodule
`default_nettype wire

// ===== common/rales_pkg.sv
// constants and types shared by the alarm and indicator encoder
`default_nettype none
package rales_pkg;

  // ************************************************************
  // register map (byte addresses, one aligned word each)
  // ************************************************************
  localparam int          ADDR_W       = 8;
  localparam logic [7:0]  CTRL_OFS     = 8'h00;
  localparam logic [7:0]  STATE_OFS    = 8'h04;
  localparam logic [7:0]  ISTAT_OFS    = 8'h08;
  localparam logic [7:0]  IMASK_OFS    = 8'h0c;

  // control register fields
  localparam int          CTRL_W       = 4;
  localparam int          CTRL_OUT_ON  = 0;  // serial mode output request
  localparam int          CTRL_ANALOG  = 1;  // analog mode instead of bus
  localparam int          CTRL_SVC_REQ = 2;  // service request
  localparam int          CTRL_COMM    = 3;  // communications fault
  localparam logic [3:0]  CTRL_RST     = 4'h1;

  // interrupt event bits, same layout in status and mask
  localparam int          EV_W         = 4;
  localparam int          EV_FAULT     = 0;
  localparam int          EV_OTW       = 1;
  localparam int          EV_PFW       = 2;
  localparam int          EV_CAP       = 3;
  localparam logic [3:0]  IMASK_RST    = 4'h0;

  // axi responses
  localparam logic [1:0]  RESP_OKAY    = 2'h0;
  localparam logic [1:0]  RESP_SLVERR  = 2'h2;

  // ************************************************************
  // timing
  // ************************************************************
  localparam int          CLK_HZ        = 20_000_000;
  localparam int          PFW_LEAD_US   = 5000;   // 5 ms warning lead
  localparam int          PFW_LEAD_CYC  = PFW_LEAD_US * (CLK_HZ / 1_000_000);
  localparam int          BLINK_HALF_MS = 250;    // indicator blink half period
  localparam int          BLINK_HALF_CYC = BLINK_HALF_MS * (CLK_HZ / 1000);
  localparam int          THERM_MARGIN_C = 5;     // set by the sensor threshold

  // operating modes
  typedef enum logic [1:0] {
    MODE_ANALOG,
    MODE_BUS,
    MODE_SERIAL
  } rales_mode_e;

endpackage
`default_nettype wire

// ===== hdl/rales_blink.sv
// blink generator: square wave from a cycle divider
`default_nettype none
module rales_blink #(
  parameter int HALF_CYC = rales_pkg::BLINK_HALF_CYC
) (
  // clock and reset
  input  wire logic aclk,
  input  wire logic aresetn,
  // blink phase
  output var  logic blink
);
  import rales_pkg::*;

  logic [31:0] cnt_r;
  logic [31:0] cnt_nxt;
  logic        ph_r;
  logic        ph_nxt;

  // divider; phase flips once per half period
  always_comb begin
    cnt_nxt = cnt_r + 32'h1;
    ph_nxt  = ph_r;
    if (cnt_r >= 32'(HALF_CYC - 1)) begin
      cnt_nxt = 32'h0;
      ph_nxt  = ~ph_r;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_r <= 32'h0;
      ph_r  <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      ph_r  <= ph_nxt;
    end
  end

  assign blink = ph_r;
endmodule
`default_nettype wire

// ===== test/rales_monitor.sv
// checker for the alarm and indicator encoder pins
`default_nettype none
module rales_monitor (
  // clock and reset
  input wire logic aclk, aresetn,
  // condition and control pins
  input wire logic thermal_alarm, thermal_shutdown, fan_fail, fuse_blown,
  input wire logic boost_fail, ov_latched, input_present, input_in_limits,
  input wire logic over_current, boost_decayed, full_rating, internal_fail,
  input wire logic onoff_n, mux_reset_req_n,
  // indicators, alarm enables and power train
  input wire logic led_input_good, led_output_good, led_service, led_fault,
  input wire logic fault_oe, otw_oe, power_fail_warning_oe,
  input wire logic capacity_level_oe, main_output_on, mux_reset
);
  // ******************************
  // settle counter
  // ******************************
  logic [2:0] up_r;
  logic [2:0] up_nxt;
  // $past reaches 3 edges back, so early edges see reset values
  always_comb begin
    up_nxt = (up_r == 3'h5) ? up_r : up_r + 3'h1;
  end
  always_ff @(posedge aclk) begin
    up_r <= aresetn ? up_nxt : 3'h0;
  end
  // condition groups: shutdown causes, and nothing above the normal tier
  wire logic ok = (up_r == 3'h5);
  wire logic hard = thermal_shutdown | fan_fail | fuse_blown
    | boost_fail | ov_latched;
  wire logic calm = input_present & ~hard & input_in_limits
    & ~over_current & ~boost_decayed;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence thermal_warm;
    ok ##0 main_output_on ##0 $past(calm & thermal_alarm, 3);
  endsequence
  a_input_lost_dark: assert property (
    ok && $past(!input_present, 3) |-> power_fail_warning_oe && !fault_oe
    && !otw_oe && !(led_input_good | led_output_good | led_service
    | led_fault)) else $error("no input state wrong");
  a_shutdown_all_low: assert property (
    ok && $past(input_present & thermal_shutdown, 3) |-> fault_oe && otw_oe
    && power_fail_warning_oe && !led_output_good && led_service && led_fault)
    else $error("thermal shutdown state wrong");
  a_fatal_fault: assert property (
    ok && $past(input_present & ~thermal_shutdown & (fan_fail | fuse_blown
    | boost_fail | ov_latched), 3) |-> fault_oe && power_fail_warning_oe
    && !otw_oe && led_input_good && !led_output_good && led_fault)
    else $error("shutdown fault state wrong");
  a_thermal_warn: assert property (
    thermal_warm |-> otw_oe && led_service && !power_fail_warning_oe
    && led_input_good && led_output_good) else $error("thermal alarm wrong");
  a_fault_idle: assert property (
    ok && $past(input_present & ~hard & ~internal_fail, 3) |-> !fault_oe)
    else $error("fault pulled without cause");
  a_capacity_level: assert property (
    ok |-> capacity_level_oe == $past(!full_rating, 3))
    else $error("capacity level wrong");
  a_hot_plug_gate: assert property (
    (ok && onoff_n) [*8] ##1 onoff_n [*4] |-> !main_output_on)
    else $error("output on while hot plug pin open");
  a_mux_reset_follow: assert property (
    ok |-> mux_reset == $past(!mux_reset_req_n, 3))
    else $error("mux reset does not follow request");
endmodule
bind rales_top rales_monitor mon (.*);
`default_nettype wire

// ===== test/rales_shelf.sv
// shelf controller model: pull-ups on alarm lines, drives control pins
`default_nettype none
module rales_shelf (
  // open-drain enables from the rectifier
  input wire logic fault_oe, otw_oe, power_fail_warning_oe,
  input wire logic capacity_level_oe, module_present_flag_oe,
  // wanted control pin state
  input wire logic out_req, hot_in, strap_fit, mux_rst,
  // pin levels as the shelf sees them
  output logic fault_pin, otw_pin, pfw_pin, cap_pin, pres_pin,
  // control pins into the rectifier
  output logic output_enable_n, onoff_n, protocol_strap, mux_reset_req_n
);
  // ******************************
  // pin levels
  // ******************************
  // released lines float up to the pull-up, never keep a stale low
  assign fault_pin = !fault_oe;
  assign otw_pin = !otw_oe;
  assign pfw_pin = !power_fail_warning_oe;
  assign cap_pin = !capacity_level_oe;
  assign pres_pin = !module_present_flag_oe;
  // enable shorted to logic ground turns the output on
  assign output_enable_n = !out_req;
  assign onoff_n = !hot_in;
  // strap fitted picks serial, left open picks bus mode
  assign protocol_strap = strap_fit;
  assign mux_reset_req_n = !mux_rst;
endmodule
`default_nettype wire

// ===== test/tb.sv
// self-checking bench for the alarm and indicator encoder
`default_nettype none
module tb;
  import rales_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  // ******************************
  // signals
  // ******************************
  logic aclk, aresetn;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rdat;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, rrsp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready;
  logic thermal_alarm, thermal_shutdown, fan_fail, fuse_blown, boost_fail;
  logic ov_latched, input_present, input_in_limits, over_current;
  logic internal_fail, boost_decayed, full_rating;
  logic output_enable_n, onoff_n, protocol_strap, mux_reset_req_n;
  logic led_input_good, led_output_good, led_service, led_fault;
  logic fault_o, fault_oe, power_fail_warning_o, power_fail_warning_oe;
  logic otw_o, otw_oe, capacity_level_o, capacity_level_oe;
  logic module_present_flag_o, module_present_flag_oe;
  logic main_output_on, mux_reset, irq;
  logic fault_pin, otw_pin, pfw_pin, cap_pin, pres_pin;
  logic out_req, hot_in, strap_fit, mux_rst;
  int err_total = 0;
  int comparisons = 0;
  wire logic [6:0] pins = {fault_pin, otw_pin, pfw_pin, led_input_good,
    led_output_good, led_service, led_fault};
  // short counts keep the run small
  rales_top #(.PFW_LEAD_CYC(8), .BLINK_HALF_CYC(4)) uut (.*);
  rales_shelf shelf (.*);
  always #25 aclk = ~aclk;
  // condition bits, then pin levels {fault,otw,pfw,ig,og,svc,flt}
  function automatic logic [14:0] plan(input int id);
    case (id)
      0: return {8'h01, 7'h7c};
      1: return {8'h81, 7'h5e};
      2: return {8'h41, 7'h0b};
      3: return {8'h21, 7'h29};
      4: return {8'h11, 7'h29};
      5: return {8'h09, 7'h29};
      6: return {8'h05, 7'h29};
      7: return {8'h03, 7'h3d};
      default: return {8'h00, 7'h60};
    endcase
  endfunction
  task chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    comparisons++;
    if (s !== e) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", nm, e, s);
    end
  endtask
  task settle(input int n);
    repeat (n) @(posedge aclk);
    @(negedge aclk);
  endtask
  // bus master: valid held until its ready, bready held till bvalid
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    {s_axi_awaddr, s_axi_wdata} <= {a, d};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    chk("bresp", {30'h0, RESP_OKAY}, {30'h0, s_axi_bresp});
  endtask
  task rd(input logic [7:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    {rdat, rrsp} = {s_axi_rdata, s_axi_rresp};
    s_axi_rready <= 1'b0;
  endtask
  // one condition row, random capacity rating alongside
  task run_case(input int id);
    logic [14:0] p;
    p = plan(id);
    @(posedge aclk);
    {thermal_alarm, thermal_shutdown, fan_fail, fuse_blown, boost_fail,
      ov_latched, internal_fail, input_present} <= p[14:7];
    full_rating <= 1'($urandom_range(1));
    settle(6);
    chk("pins", {25'h0, p[6:0]}, {25'h0, pins});
    chk("capacity", {31'h0, full_rating}, {31'h0, cap_pin});
    chk("present", 32'h0, {31'h0, pres_pin});
    chk("drain", 32'h0, {27'h0, fault_o, otw_o, power_fail_warning_o,
      capacity_level_o, module_present_flag_o});
  endtask
  task summarize;
    $display("comparisons %0d errors %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // watchdog: far beyond the few hundred cycles the tests need
  initial begin
    repeat (20000) @(posedge aclk);
    err_total++;
    summarize();
  end
  // ******************************
  // main sequence
  // ******************************
  initial begin
    void'($urandom(89701));
    {aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr} = '0;
    {s_axi_wdata, s_axi_wstrb} = {32'h0, 4'hf};
    {thermal_alarm, thermal_shutdown, fan_fail, fuse_blown} = '0;
    {boost_fail, ov_latched, input_present, internal_fail} = '0;
    {input_in_limits, over_current, boost_decayed, full_rating} = 4'h8;
    {out_req, hot_in, strap_fit, mux_rst} = 4'hc;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    rd(CTRL_OFS);
    chk("ctrl reset", 32'h1, rdat);
    for (int i = 0; i < 9; i++) run_case(i);
    repeat (30) run_case($urandom_range(8));
    wr(IMASK_OFS, 32'h1);
    run_case(0);
    wr(ISTAT_OFS, 32'hf);
    run_case(7);
    rd(ISTAT_OFS);
    chk("fault event", 32'h1, rdat & 32'h1);
    chk("irq raised", 32'h1, {31'h0, irq});
    wr(IMASK_OFS, 32'h0);
    settle(3);
    chk("irq masked", 32'h0, {31'h0, irq});
    run_case(0);
    wr(ISTAT_OFS, 32'h1);
    rd(ISTAT_OFS);
    chk("event cleared", 32'h0, rdat & 32'h1);
    rd(8'h10);
    chk("unmapped resp", {30'h0, RESP_SLVERR}, {30'h0, rrsp});
    rd(STATE_OFS);
    chk("bus mode", 32'h1, (rdat >> 10) & 32'h3);
    @(posedge aclk) hot_in <= 1'b0;
    settle(14);
    chk("hot plug off", 32'h0, {31'h0, main_output_on});
    @(posedge aclk) {hot_in, out_req} <= 2'h2;
    settle(6);
    chk("enable off", 32'h0, {31'h0, main_output_on});
    @(posedge aclk) {out_req, mux_rst} <= 2'h3;
    settle(6);
    chk("mux reset", 32'h1, {31'h0, mux_reset});
    @(posedge aclk) {mux_rst, strap_fit, out_req, aresetn} <= 4'h4;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    rd(STATE_OFS);
    chk("serial mode", 32'h9, (rdat >> 8) & 32'hd);
    settle(6);
    chk("serial on", 32'h1, {31'h0, main_output_on});
    summarize();
  end
endmodule
`default_nettype wire
